//--- design/rcad_core.sv
// Purpose: two-stage fetch/execute core with 8-bit datapath and multiplier
// Assumes: program memory answers prog_addr combinationally in the same cycle
// Notes:   data file and special registers live inside the core

// Operation
// - each 16-bit instruction word is fetched whole in one cycle on its own bus
// - fetch overlaps execute; branches and table reads take two cycles
// - instruction pointer spans 64K program words of 16 bits
// - internal, external or mixed fetch; no code protection in mixed mode
// - special registers, pointer and accumulator included, sit in the data map
// - file-to-file move bypasses the working accumulator
// - 8-bit alu adds, subtracts, shifts and does logic with accumulator and file
// - arithmetic is two's complement with no signed hardware
// - carry, nibble carry and zero flags update on add and subtract; logic ops set only zero, rotates only carry
// - in subtraction carry and nibble carry mean no borrow
// - overflow flag comes only from bit 6 and bit 7 carries
// - optional 8 x 8 multiplier yields a 16-bit product in one cycle
module rcad_core #(
  parameter int unsigned INT_WORDS = 8192,
  parameter bit          HAS_MUL   = 1'b1
) (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic [1:0]  mode_strap,
  output logic      [15:0] prog_addr,
  input  wire logic [15:0] prog_data,
  output logic             prog_ext,
  output logic             code_protect,
  output logic      [1:0]  exec_mode,
  output logic      [7:0]  working_accumulator,
  output logic      [7:0]  status_flags,
  output logic      [15:0] product,
  output logic             run_active
);
  rcad_pkg::rcad_state_t state_q;
  rcad_pkg::rcad_state_t state_d;
  logic [1:0]  mode_s1_q;
  logic [1:0]  mode_s2_q;
  logic [1:0]  mode_q;
  logic [1:0]  mode_d;
  logic [1:0]  boot_cnt_q;
  logic [15:0] prog_addr_q;
  logic [15:0] prog_addr_d;
  logic [15:0] resume_q;
  logic [15:0] ir_q;
  logic [15:0] prod_q;
  logic [15:0] mul_res;
  logic [15:0] goto_tgt;
  logic        ir_valid_q;
  logic        prog_ext_q;
  logic        code_protect_q;
  logic        run_q;
  logic        tbl_hi_sel_q;
  logic [7:0]  working_accumulator_q;
  logic [7:0]  status_q;
  logic [7:0]  ptr_q;
  logic [7:0]  tbl_lo_q;
  logic [7:0]  tbl_hi_q;
  logic [7:0]  tbl_dst_q;
  logic [7:0]  file_q [256];
  logic [3:0]  opc;
  logic        dst_f;
  logic        run;
  logic        exec;
  logic        in_tbl;
  logic        boot_done;
  logic        is_alu;
  logic        is_goto;
  logic        is_tbl;
  logic        is_mul;
  logic        is_movff;
  logic        is_movwf;
  logic        is_movlw;
  logic        wr_en;
  logic        ip_wr;
  logic        flush;
  logic [7:0]  fa;
  logic [7:0]  rd_val;
  logic [7:0]  alu_res;
  logic [7:0]  wr_addr;
  logic [7:0]  wr_data;
  logic [7:0]  w_d;
  logic [7:0]  status_w;
  logic [7:0]  status_d;
  logic [3:0]  alu_flags;
  logic [3:0]  alu_aff;

  // fetch goes off chip in processor mode, or above internal words in mixed mode
  function automatic logic ext_fetch(input logic [15:0] a, input logic [1:0] m);
    return (m == rcad_pkg::MODE_MPU) ||
           ((m == rcad_pkg::MODE_EXT) && ({16'h0000, a} >= 32'(INT_WORDS)));
  endfunction : ext_fetch

  function automatic logic sfr_hit(input logic en, input logic [7:0] a,
                                   input logic [7:0] sfr);
    return en && (a == sfr);
  endfunction : sfr_hit

  assign run       = (state_q == rcad_pkg::ST_RUN);
  assign in_tbl    = (state_q == rcad_pkg::ST_TBL);
  assign exec      = run && ir_valid_q;
  assign boot_done = (state_q == rcad_pkg::ST_BOOT) && (boot_cnt_q == rcad_pkg::BOOT_WAIT);
  assign opc       = ir_q[15:12];
  assign dst_f     = ir_q[rcad_pkg::IR_DST];
  // indirect slot reads and writes through the pointer register
  assign fa        = (ir_q[7:0] == rcad_pkg::FA_IND) ? ptr_q : ir_q[7:0];
  assign is_alu    = exec && (opc >= rcad_pkg::OP_ADD) && (opc <= rcad_pkg::OP_RRC);
  assign is_goto   = exec && (opc == rcad_pkg::OP_GOTO);
  assign is_tbl    = exec && (opc == rcad_pkg::OP_TBLRD);
  assign is_mul    = exec && (opc == rcad_pkg::OP_MULWF);
  assign is_movff  = exec && (opc == rcad_pkg::OP_MOVFF);
  assign is_movwf  = exec && (opc == rcad_pkg::OP_MOVWF);
  assign is_movlw  = exec && (opc == rcad_pkg::OP_MOVLW);
  assign goto_tgt  = {prog_addr_q[15:12], ir_q[11:0]};
  assign mul_res   = {8'h00, working_accumulator_q} * {8'h00, rd_val};
  assign mode_d    = boot_done ? mode_s2_q : mode_q;

  // special registers answer at their data addresses
  always_comb begin
    if (fa == rcad_pkg::FA_PTR) begin
      rd_val = ptr_q;
    end else if (fa == rcad_pkg::FA_IP_LO) begin
      rd_val = prog_addr_q[7:0];
    end else if (fa == rcad_pkg::FA_IP_HI) begin
      rd_val = prog_addr_q[15:8];
    end else if (fa == rcad_pkg::FA_STATUS) begin
      rd_val = status_q;
    end else if (fa == rcad_pkg::FA_WORKING_ACCUMULATOR) begin
      rd_val = working_accumulator_q;
    end else if (fa == rcad_pkg::FA_TBL_LO) begin
      rd_val = tbl_lo_q;
    end else if (fa == rcad_pkg::FA_TBL_HI) begin
      rd_val = tbl_hi_q;
    end else if (fa == rcad_pkg::FA_PROD_LO) begin
      rd_val = prod_q[7:0];
    end else if (fa == rcad_pkg::FA_PROD_HI) begin
      rd_val = prod_q[15:8];
    end else begin
      rd_val = file_q[fa];
    end
  end

  rcad_alu u_alu (
    .opcode   (opc),
    .acc      (working_accumulator_q),
    .opnd     (rd_val),
    .carry_in (status_q[rcad_pkg::SB_C]),
    .result   (alu_res),
    .flags    (alu_flags),
    .affect   (alu_aff)
  );

  // file write port: alu result, accumulator store, file-to-file move, table byte
  assign wr_en   = (is_alu && dst_f) || is_movwf || is_movff || in_tbl;
  assign wr_addr = in_tbl   ? tbl_dst_q :
                   is_movff ? {rcad_pkg::MOVFF_PAGE, ir_q[11:8]} : fa;
  assign wr_data = in_tbl   ? (tbl_hi_sel_q ? prog_data[15:8] : prog_data[7:0]) :
                   is_movff ? rd_val :
                   is_movwf ? working_accumulator_q : alu_res;
  assign ip_wr   = sfr_hit(wr_en, wr_addr, rcad_pkg::FA_IP_LO);
  assign flush   = is_goto || ip_wr;
  assign w_d     = sfr_hit(wr_en, wr_addr, rcad_pkg::FA_WORKING_ACCUMULATOR) ? wr_data :
                   (is_alu && !dst_f) ? alu_res :
                   is_movlw ? ir_q[7:0] : working_accumulator_q;
  // alu flags win over a plain write to the status byte
  assign status_w = sfr_hit(wr_en, wr_addr, rcad_pkg::FA_STATUS) ? wr_data : status_q;
  assign status_d = is_alu ? ((status_w & ~{4'h0, alu_aff}) | {4'h0, alu_flags & alu_aff}) :
                    status_w;

  // next fetch address, 16 bits wide so it wraps over 64K words
  always_comb begin
    prog_addr_d = prog_addr_q + 16'h0001;
    state_d     = state_q;
    case (state_q)
      rcad_pkg::ST_BOOT: begin
        prog_addr_d = rcad_pkg::RESET_VECTOR;
        state_d     = boot_done ? rcad_pkg::ST_RUN : rcad_pkg::ST_BOOT;
      end
      rcad_pkg::ST_RUN: begin
        if (is_goto) begin
          prog_addr_d = goto_tgt;
        end else if (ip_wr) begin
          prog_addr_d = {prog_addr_q[15:8], wr_data};
        end else if (is_tbl) begin
          prog_addr_d = {tbl_hi_q, tbl_lo_q};
          state_d     = rcad_pkg::ST_TBL;
        end
      end
      rcad_pkg::ST_TBL: begin
        prog_addr_d = resume_q;
        state_d     = rcad_pkg::ST_RUN;
      end
      default: begin
        prog_addr_d = rcad_pkg::RESET_VECTOR;
        state_d     = rcad_pkg::ST_BOOT;
      end
    endcase
  end

  // strap is a pin: two stages before use, captured after reset release
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mode_s1_q  <= rcad_pkg::MODE_MCU;
      mode_s2_q  <= rcad_pkg::MODE_MCU;
      mode_q     <= rcad_pkg::MODE_MCU;
      boot_cnt_q <= 2'h0;
    end else begin
      mode_s1_q  <= mode_strap;
      mode_s2_q  <= mode_s1_q;
      mode_q     <= mode_d;
      boot_cnt_q <= boot_done ? boot_cnt_q : boot_cnt_q + 2'h1;
    end
  end

  // fetch/execute pipeline: the word on the bus this cycle runs next cycle
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_q        <= rcad_pkg::ST_BOOT;
      prog_addr_q    <= rcad_pkg::RESET_VECTOR;
      prog_ext_q     <= 1'b0;
      code_protect_q <= 1'b0;
      run_q          <= 1'b0;
      ir_q           <= 16'h0000;
      ir_valid_q     <= 1'b0;
      resume_q       <= 16'h0000;
      tbl_dst_q      <= 8'h00;
      tbl_hi_sel_q   <= 1'b0;
    end else begin
      state_q        <= state_d;
      prog_addr_q    <= prog_addr_d;
      prog_ext_q     <= ext_fetch(prog_addr_d, mode_d);
      code_protect_q <= (mode_d == rcad_pkg::MODE_PMCU);
      run_q          <= (state_d != rcad_pkg::ST_BOOT);
      if (run) begin
        ir_q       <= prog_data;
        ir_valid_q <= !flush;
      end
      if (is_tbl) begin
        resume_q     <= prog_addr_q + 16'h0001;
        tbl_dst_q    <= fa;
        tbl_hi_sel_q <= dst_f;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      working_accumulator_q   <= 8'h00;
      status_q <= rcad_pkg::STATUS_RST;
      ptr_q    <= 8'h00;
      tbl_lo_q <= 8'h00;
      tbl_hi_q <= 8'h00;
      prod_q   <= 16'h0000;
    end else begin
      working_accumulator_q   <= w_d;
      status_q <= status_d;
      if (sfr_hit(wr_en, wr_addr, rcad_pkg::FA_PTR)) ptr_q <= wr_data;
      if (sfr_hit(wr_en, wr_addr, rcad_pkg::FA_TBL_LO)) tbl_lo_q <= wr_data;
      if (sfr_hit(wr_en, wr_addr, rcad_pkg::FA_TBL_HI)) tbl_hi_q <= wr_data;
      if (is_mul && HAS_MUL) begin
        prod_q <= mul_res;
      end else if (sfr_hit(wr_en, wr_addr, rcad_pkg::FA_PROD_LO)) begin
        prod_q[7:0] <= wr_data;
      end else if (sfr_hit(wr_en, wr_addr, rcad_pkg::FA_PROD_HI)) begin
        prod_q[15:8] <= wr_data;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (wr_en) file_q[wr_addr] <= wr_data;
  end

  assign prog_addr           = prog_addr_q;
  assign prog_ext            = prog_ext_q;
  assign code_protect        = code_protect_q;
  assign exec_mode           = mode_q;
  assign working_accumulator = working_accumulator_q;
  assign status_flags        = status_q;
  assign product             = prod_q;
  assign run_active          = run_q;

  // checks
  logic nib_carry;
  logic ov_ref;
  assign nib_carry = ({1'b0, rd_val[3:0]} + {1'b0, working_accumulator_q[3:0]}) > 5'h0F;
  assign ov_ref    = (working_accumulator_q[7] == rd_val[7]) && (alu_res[7] != working_accumulator_q[7]);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  sequence s_refill;
    !ir_valid_q ##1 (run && ir_valid_q);
  endsequence
  sequence s_tbl_then_run;
    in_tbl ##1 (run && ir_valid_q);
  endsequence

  property p_fetch_word;
    run |=> (ir_q == $past(prog_data));
  endproperty
  a_fetch_word: assert property (p_fetch_word) else $error("fetch word lost");
  property p_single_cycle;
    (is_alu || is_movlw || is_mul || is_movff || is_movwf) && !ip_wr
      |=> ir_valid_q && (prog_addr_q == $past(prog_addr_q) + 16'h0001);
  endproperty
  a_single_cycle: assert property (p_single_cycle) else $error("stall on plain op");
  property p_branch_two;
    is_goto |=> (prog_addr_q == $past(goto_tgt)) ##0 s_refill;
  endproperty
  a_branch_two: assert property (p_branch_two) else $error("branch timing");
  property p_tbl_two;
    is_tbl |=> (prog_addr_q == {$past(tbl_hi_q), $past(tbl_lo_q)}) ##0 s_tbl_then_run;
  endproperty
  a_tbl_two: assert property (p_tbl_two) else $error("table read timing");
  property p_wrap;
    run && !flush && !is_tbl && (prog_addr_q == 16'hFFFF) |=> prog_addr_q == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("pointer not 16 bit");
  property p_protect;
    run |-> (code_protect_q == (mode_q == rcad_pkg::MODE_PMCU)) &&
            !(code_protect_q && (mode_q == rcad_pkg::MODE_EXT));
  endproperty
  a_protect: assert property (p_protect) else $error("protect in mixed mode");
  property p_ext_mpu;
    run && (mode_q == rcad_pkg::MODE_MPU) |-> prog_ext_q;
  endproperty
  a_ext_mpu: assert property (p_ext_mpu) else $error("processor mode fetch internal");
  property p_sfr_map;
    is_movwf && (fa == rcad_pkg::FA_PTR) |=> ptr_q == $past(working_accumulator_q);
  endproperty
  a_sfr_map: assert property (p_sfr_map) else $error("pointer not mapped");
  property p_movff;
    is_movff |=> working_accumulator_q == $past(working_accumulator_q);
  endproperty
  a_movff: assert property (p_movff) else $error("move touched accumulator");
  property p_alu_w;
    is_alu && !dst_f |=> working_accumulator_q == $past(alu_res);
  endproperty
  a_alu_w: assert property (p_alu_w) else $error("accumulator not updated");
  property p_zero;
    is_alu && alu_aff[rcad_pkg::SB_Z] |=> status_q[rcad_pkg::SB_Z] == ($past(alu_res) == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  property p_borrow;
    is_alu && (opc == rcad_pkg::OP_SUB) |=> status_q[rcad_pkg::SB_C] == ($past(rd_val) >= $past(working_accumulator_q));
  endproperty
  a_borrow: assert property (p_borrow) else $error("borrow wrong");
  property p_nibble;
    is_alu && (opc == rcad_pkg::OP_ADD) |=> status_q[rcad_pkg::SB_DC] == $past(nib_carry);
  endproperty
  a_nibble: assert property (p_nibble) else $error("nibble carry wrong");
  property p_ovf;
    is_alu && (opc == rcad_pkg::OP_ADD) |=> status_q[rcad_pkg::SB_OV] == $past(ov_ref);
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow wrong");
  property p_mul;
    is_mul |=> prod_q == (HAS_MUL ? $past(mul_res) : $past(prod_q));
  endproperty
  a_mul: assert property (p_mul) else $error("product wrong");
endmodule : rcad_core

//--- design/rcad_pkg.sv
// Purpose: shared constants for the risc core alu datapath
// Assumes: one clock domain, 8-bit data words, 16-bit program words
// Notes:   opcode layout and file map belong to this core only
package rcad_pkg;
  // opcode field ir[15:12]
  localparam logic [3:0] OP_NOP   = 4'h0;
  localparam logic [3:0] OP_ADD   = 4'h1;
  localparam logic [3:0] OP_SUB   = 4'h2;
  localparam logic [3:0] OP_AND   = 4'h3;
  localparam logic [3:0] OP_IOR   = 4'h4;
  localparam logic [3:0] OP_XOR   = 4'h5;
  localparam logic [3:0] OP_RLC   = 4'h6;
  localparam logic [3:0] OP_RRC   = 4'h7;
  localparam logic [3:0] OP_MOVLW = 4'h8;
  localparam logic [3:0] OP_MOVWF = 4'h9;
  localparam logic [3:0] OP_MULWF = 4'hA;
  localparam logic [3:0] OP_MOVFF = 4'hB;
  localparam logic [3:0] OP_GOTO  = 4'hC;
  localparam logic [3:0] OP_TBLRD = 4'hD;
  // field positions
  localparam int unsigned IR_DST  = 8;
  // data file map of the special registers
  localparam logic [7:0] FA_IND    = 8'h00;
  localparam logic [7:0] FA_PTR    = 8'h01;
  localparam logic [7:0] FA_IP_LO  = 8'h02;
  localparam logic [7:0] FA_IP_HI  = 8'h03;
  localparam logic [7:0] FA_STATUS = 8'h04;
  localparam logic [7:0] FA_WORKING_ACCUMULATOR   = 8'h0A;
  localparam logic [7:0] FA_TBL_LO = 8'h0D;
  localparam logic [7:0] FA_TBL_HI = 8'h0E;
  localparam logic [7:0] FA_PROD_LO = 8'h18;
  localparam logic [7:0] FA_PROD_HI = 8'h19;
  localparam logic [3:0] MOVFF_PAGE = 4'h2;
  // status bit positions
  localparam int unsigned SB_C  = 0;
  localparam int unsigned SB_DC = 1;
  localparam int unsigned SB_Z  = 2;
  localparam int unsigned SB_OV = 3;
  // flag masks per operation class
  localparam logic [3:0] AFF_ARITH = 4'hF;
  localparam logic [3:0] AFF_LOGIC = 4'h4;
  localparam logic [3:0] AFF_ROT   = 4'h1;
  localparam logic [3:0] AFF_NONE  = 4'h0;
  // execution modes taken from the strap
  localparam logic [1:0] MODE_MCU  = 2'h0;
  localparam logic [1:0] MODE_PMCU = 2'h1;
  localparam logic [1:0] MODE_EXT  = 2'h2;
  localparam logic [1:0] MODE_MPU  = 2'h3;
  // values after reset and counts
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [7:0]  STATUS_RST   = 8'h00;
  localparam logic [1:0]  BOOT_WAIT    = 2'h2;
  typedef enum logic [1:0] {
    ST_BOOT = 2'h0,
    ST_RUN  = 2'h1,
    ST_TBL  = 2'h3
  } rcad_state_t;
endpackage : rcad_pkg

//--- design/rcad_alu.sv
// Purpose: 8-bit alu between the working accumulator and a file operand
// Assumes: purely combinational, driven by the core's execute stage
// Notes:   sub computes opnd - acc, carry means no borrow
module rcad_alu (
  input  wire logic [3:0] opcode,
  input  wire logic [7:0] acc,
  input  wire logic [7:0] opnd,
  input  wire logic       carry_in,
  output logic      [7:0] result,
  output logic      [3:0] flags,
  output logic      [3:0] affect
);
  logic       is_sub;
  logic [7:0] addend;
  logic [8:0] sum9;
  logic [4:0] nib;
  logic [7:0] low7;
  logic       rot_c;
  logic       is_rot;

  // plain unsigned adder, two's complement by nature
  assign is_sub = (opcode == rcad_pkg::OP_SUB);
  assign addend = is_sub ? ~acc : acc;
  assign sum9   = {1'b0, opnd} + {1'b0, addend} + {8'h00, is_sub};
  // carry out of bit 3, inverted sense gives digit borrow
  assign nib    = {1'b0, opnd[3:0]} + {1'b0, addend[3:0]} + {4'h0, is_sub};
  assign low7   = {1'b0, opnd[6:0]} + {1'b0, addend[6:0]} + {7'h00, is_sub};
  assign is_rot = (opcode == rcad_pkg::OP_RLC) || (opcode == rcad_pkg::OP_RRC);
  assign rot_c  = (opcode == rcad_pkg::OP_RLC) ? opnd[7] : opnd[0];

  always_comb begin
    result = opnd;
    affect = rcad_pkg::AFF_NONE;
    case (opcode)
      rcad_pkg::OP_ADD,
      rcad_pkg::OP_SUB: begin
        result = sum9[7:0];
        affect = rcad_pkg::AFF_ARITH;
      end
      rcad_pkg::OP_AND: begin
        result = acc & opnd;
        affect = rcad_pkg::AFF_LOGIC;
      end
      rcad_pkg::OP_IOR: begin
        result = acc | opnd;
        affect = rcad_pkg::AFF_LOGIC;
      end
      rcad_pkg::OP_XOR: begin
        result = acc ^ opnd;
        affect = rcad_pkg::AFF_LOGIC;
      end
      rcad_pkg::OP_RLC: begin
        result = {opnd[6:0], carry_in};
        affect = rcad_pkg::AFF_ROT;
      end
      rcad_pkg::OP_RRC: begin
        result = {carry_in, opnd[7:1]};
        affect = rcad_pkg::AFF_ROT;
      end
      default: begin
        result = opnd;
        affect = rcad_pkg::AFF_NONE;
      end
    endcase
  end

  assign flags[rcad_pkg::SB_C]  = is_rot ? rot_c : sum9[8];
  assign flags[rcad_pkg::SB_DC] = nib[4];
  assign flags[rcad_pkg::SB_Z]  = (result == 8'h00);
  // carry into bit 7 against carry out of bit 7
  assign flags[rcad_pkg::SB_OV] = low7[7] ^ sum9[8];
endmodule : rcad_alu

//--- test/rcad_prog_model.sv
// Purpose: program memory model on the core's fetch bus
// Assumes: words are loaded by the bench while the core is held in reset
// Notes:   words never loaded read as nop
module rcad_prog_model (
  input  wire logic        clk_sys,
  input  wire logic        ld_en,
  input  wire logic [15:0] ld_addr,
  input  wire logic [15:0] ld_data,
  input  wire logic [15:0] prog_addr,
  output logic      [15:0] prog_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:65535];
  initial begin
    foreach (mem[i]) mem[i] = 16'h0000;
  end
  always @(posedge clk_sys) begin
    if (ld_en) mem[ld_addr] <= ld_data;
  end
  // whole word in the same cycle, full address span
  assign prog_data = mem[prog_addr];
endmodule : rcad_prog_model

//--- test/test_risc_core_alu_datapath.sv
// Purpose: self-checking bench for the core, one program run per mode
// Assumes: the memory model answers combinationally
// Notes:   each block loads two operands, moves, multiplies, then runs one alu op
module test_risc_core_alu_datapath;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned NB  = 14;
  localparam logic [15:0] TGT = 16'h0F00;
  logic        clk_sys, arst_n, ld_en, prog_ext, code_protect, run_active;
  logic [1:0]  mode_strap, exec_mode;
  logic [15:0] prog_addr, prog_data, ld_addr, ld_data, product, r, b0;
  logic [7:0]  working_accumulator, status_flags, st, fa [NB], fb [NB];
  logic [3:0]  fop [NB];
  logic [31:0] rng;
  int          n_errors, check_count, cyc, n;

  rcad_core #(.INT_WORDS(256), .HAS_MUL(1'b1)) u_dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .mode_strap(mode_strap),
    .prog_addr(prog_addr), .prog_data(prog_data), .prog_ext(prog_ext),
    .code_protect(code_protect), .exec_mode(exec_mode),
    .working_accumulator(working_accumulator), .status_flags(status_flags),
    .product(product), .run_active(run_active));
  rcad_prog_model u_mem (
    .clk_sys(clk_sys), .ld_en(ld_en), .ld_addr(ld_addr), .ld_data(ld_data),
    .prog_addr(prog_addr), .prog_data(prog_data));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  // expected {status, result}; sub is f - w with carry meaning no borrow
  function automatic logic [15:0] calc(input logic [3:0] op, input logic [7:0] f,
                                       input logic [7:0] w, input logic [7:0] s0);
    logic       sb;
    logic [7:0] v, q, rr, t;
    logic [8:0] s;
    logic [4:0] h;
    sb = (op == rcad_pkg::OP_SUB);
    v  = sb ? ~w : w;
    s  = {1'b0, f} + {1'b0, v} + {8'h00, sb};
    h  = {1'b0, f[3:0]} + {1'b0, v[3:0]} + {4'h0, sb};
    q  = {1'b0, f[6:0]} + {1'b0, v[6:0]} + {7'h00, sb};
    t  = s0;
    case (op)
      rcad_pkg::OP_AND: rr = f & w;
      rcad_pkg::OP_IOR: rr = f | w;
      rcad_pkg::OP_XOR: rr = f ^ w;
      rcad_pkg::OP_RLC: rr = {f[6:0], s0[0]};
      rcad_pkg::OP_RRC: rr = {s0[0], f[7:1]};
      default:          rr = s[7:0];
    endcase
    if (op <= rcad_pkg::OP_SUB) t[3:0] = {q[7] ^ s[8], rr == 8'h00, h[4], s[8]};
    else if (op <= rcad_pkg::OP_XOR) t[2] = (rr == 8'h00);
    else t[0] = (op == rcad_pkg::OP_RLC) ? f[7] : f[0];
    return {t, rr};
  endfunction : calc

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic put(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    ld_en   = 1'b1;
    ld_addr = a;
    ld_data = d;
  endtask : put

  task automatic wait_addr(input logic [15:0] a, output int k);
    k = 0;
    while (prog_addr !== a && k < 60) begin
      @(negedge clk_sys);
      k++;
    end
    chk(prog_addr, a, "fetch address");
  endtask : wait_addr

  initial begin
    arst_n = 1'b0;
    mode_strap = 2'h0;
    ld_en = 1'b0;
    ld_addr = 16'h0000;
    ld_data = 16'h0000;
    rng = 32'h0000D9C7;
    for (int m = 0; m < 4; m++) begin
      @(negedge clk_sys);
      arst_n = 1'b0;
      mode_strap = 2'(m);
      for (int i = 0; i < NB; i++) begin
        rng = xs(rng);
        fop[i] = 4'h1 + 4'(i % 7);
        {fa[i], fb[i]} = rng[15:0];
        case (i)
          0: {fa[i], fb[i]} = 16'hFF01;
          1: {fa[i], fb[i]} = 16'h0001;
          7: {fa[i], fb[i]} = 16'h7F01;
          8: {fa[i], fb[i]} = 16'h5A5A;
          default: ;
        endcase
        b0 = 16'(6 * i);
        put(b0, {rcad_pkg::OP_MOVLW, 4'h0, fa[i]});
        put(b0 + 16'h1, {rcad_pkg::OP_MOVWF, 4'h1, 8'h40});
        put(b0 + 16'h2, {rcad_pkg::OP_MOVFF, 4'h1, 8'h40});
        put(b0 + 16'h3, {rcad_pkg::OP_MOVLW, 4'h0, fb[i]});
        put(b0 + 16'h4, {rcad_pkg::OP_MULWF, 4'h1, 8'h21});
        put(b0 + 16'h5, {fop[i], 4'h0, 8'h21});
      end
      put(16'(6 * NB), {rcad_pkg::OP_GOTO, TGT[11:0]});
      put(16'(6 * NB + 1), {rcad_pkg::OP_MOVLW, 12'h033});
      put(TGT, {rcad_pkg::OP_MOVLW, 12'h05A});
      put(TGT + 16'h1, {rcad_pkg::OP_GOTO, 12'hF02});
      // pointer, table read through the indirect slot, then a jump by writing the instruction pointer low byte
      put(TGT + 16'h2, {rcad_pkg::OP_MOVWF, 4'h1, 8'h01});
      put(TGT + 16'h3, {rcad_pkg::OP_MOVLW, 4'h0, 8'h0F});
      put(TGT + 16'h4, {rcad_pkg::OP_MOVWF, 4'h1, 8'h0E});
      put(TGT + 16'h5, {rcad_pkg::OP_MOVLW, 4'h0, 8'h00});
      put(TGT + 16'h6, {rcad_pkg::OP_MOVWF, 4'h1, 8'h0D});
      put(TGT + 16'h7, {rcad_pkg::OP_TBLRD, 4'h1, 8'h00});
      put(TGT + 16'h8, {rcad_pkg::OP_IOR, 4'h0, 8'h5A});
      put(TGT + 16'h9, {rcad_pkg::OP_MOVLW, 4'h0, 8'h0C});
      put(TGT + 16'hA, {rcad_pkg::OP_MOVWF, 4'h1, 8'h02});
      put(TGT + 16'hB, {rcad_pkg::OP_MOVLW, 4'h0, 8'h33});
      put(TGT + 16'hC, {rcad_pkg::OP_GOTO, 12'hF0C});
      @(negedge clk_sys);
      ld_en = 1'b0;
      repeat (16) @(negedge clk_sys);
      chk({15'h0, run_active}, 16'h0, "run during reset");
      arst_n = 1'b1;
      n = 0;
      while (run_active !== 1'b1 && n < 10) begin
        @(negedge clk_sys);
        n++;
      end
      chk({14'h0, exec_mode}, 16'(m), "mode");
      chk({15'h0, code_protect}, {15'h0, m == 1}, "protect");
      chk({15'h0, prog_ext}, {15'h0, m == 3}, "ext at 0");
      st = 8'h00;
      for (int i = 0; i < NB; i++) begin
        wait_addr(16'(6 * i + 7), n);
        if (i > 0) chk(16'(n), 16'h6, "block cycles");
        r = calc(fop[i], fa[i], fb[i], st);
        st = r[15:8];
        chk({8'h0, working_accumulator}, {8'h0, r[7:0]}, "result");
        chk({8'h0, status_flags}, {8'h0, st}, "status");
        chk(product, 16'(fa[i]) * 16'(fb[i]), "product");
      end
      wait_addr(TGT + 16'h1, n);
      chk({8'h0, working_accumulator}, {8'h0, r[7:0]}, "bubble");
      wait_addr(TGT + 16'h2, n);
      chk({8'h0, working_accumulator}, 16'h005A, "target");
      chk({15'h0, prog_ext}, {15'h0, m >= 2}, "ext high");
      wait_addr(TGT + 16'hA, n);
      chk({8'h0, working_accumulator}, {8'h0, rcad_pkg::OP_MOVLW, 4'h0}, "table byte");
      wait_addr(TGT + 16'hD, n);
      chk({8'h0, working_accumulator}, 16'h000C, "pointer jump");
    end
    print_verdict();
  end
endmodule : test_risc_core_alu_datapath
